// file: core/dcc_pkg.sv
package dcc_pkg;
	// bus and register widths
	localparam int DCC_DW     = 32;
	localparam int DCC_AW     = 32;
	localparam int DCC_CTRL_W = 16;
	localparam int DCC_N      = 2;
	localparam int DCC_DEC_W  = 12;

	// byte offsets of the registers
	localparam logic [11:0] DCC_OFS_CTRL = 12'h000;
	localparam logic [11:0] DCC_OFS_STAT = 12'h004;
	localparam logic [11:0] DCC_OFS_MASK = 12'h008;

	// internal register index
	localparam logic [1:0] DCC_IDX_CTRL = 2'h0;
	localparam logic [1:0] DCC_IDX_STAT = 2'h1;
	localparam logic [1:0] DCC_IDX_MASK = 2'h2;
	localparam logic [1:0] DCC_IDX_NONE = 2'h3;

	// field positions in comparator_control, unit i adds i, except the single shared idle bit and the routing bits
	localparam logic [3:0] DCC_B_IDLE  = 4'hF;
	localparam logic [3:0] DCC_B_EVT   = 4'hC;
	localparam logic [3:0] DCC_B_EN    = 4'hA;
	localparam logic [3:0] DCC_B_PAD   = 4'h8;
	localparam logic [3:0] DCC_B_RES   = 4'h6;
	localparam logic [3:0] DCC_B_INV   = 4'h4;
	// routing: plus at 2*i, minus at 2*i+1
	localparam logic [3:0] DCC_B_PLUS  = 4'h0;
	localparam logic [3:0] DCC_B_MINUS = 4'h1;
	localparam int         DCC_ROUTE_S = 2;

	// reset value and plain read/write bits of comparator_control
	localparam logic [15:0] DCC_CTRL_RST = 16'h0000;
	localparam logic [15:0] DCC_RW_MASK  = 16'h8F3F;
	localparam logic [1:0]  DCC_IRQ_RST  = 2'h0;
	localparam logic [31:0] DCC_RD_RST   = 32'h0000_0000;

	// ahb-lite codes
	localparam logic [1:0] DCC_HTRANS_NONSEQ = 2'h2;
	localparam logic       DCC_HRESP_OKAY    = 1'h0;

	// bus phase, gray along idle -> wr and rd_wait -> rd_done -> idle
	typedef enum logic [1:0] {
		DCC_BUS_IDLE    = 2'h0,
		DCC_BUS_WR      = 2'h1,
		DCC_BUS_RD_WAIT = 2'h3,
		DCC_BUS_RD_DONE = 2'h2
	} dcc_bus_t;
endpackage

// file: core/dcc_unit_if.sv
`timescale 1ns/1ps
interface dcc_unit_if;
	logic enable;
	logic invert;
	logic raw;
	logic result;
	logic change;

	modport ctrl (
		output enable,
		output invert,
		output raw,
		input  result,
		input  change
	);
	modport unit (
		input  enable,
		input  invert,
		input  raw,
		output result,
		output change
	);
endinterface

// file: core/dcc_unit.sv
`timescale 1ns/1ps
module dcc_unit (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// control side
	dcc_unit_if.unit bus
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [1:0] sync;
		logic       result;
		logic       change;
	} dcc_unit_state_t;

	dcc_unit_state_t s;
	dcc_unit_state_t next_s;

	always_comb begin
		next_s      = s;
		// raw decision is asynchronous to the clock
		next_s.sync = {s.sync[0], bus.raw};
		next_s.result = bus.enable ? (s.sync[1] ^ bus.invert) : 1'b0;
		next_s.change = bus.enable & (next_s.result != s.result);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.result = s.result;
	assign bus.change = s.change;
endmodule

// file: core/dcc_top.sv
`timescale 1ns/1ps
module dcc_top (
	// clock and reset
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_nrst,
	// ahb-lite slave
	input  wire logic                      i_hsel,
	input  wire logic [dcc_pkg::DCC_AW-1:0] i_haddr,
	input  wire logic [1:0]                i_htrans,
	input  wire logic                      i_hwrite,
	input  wire logic [2:0]                i_hsize,
	input  wire logic [dcc_pkg::DCC_DW-1:0] i_hwdata,
	input  wire logic                      i_hready,
	output logic      [dcc_pkg::DCC_DW-1:0] o_hrdata,
	output logic                           o_hreadyout,
	output logic                           o_hresp,
	// device state
	input  wire logic                      i_idle,
	// analog comparator cells
	input  wire logic [dcc_pkg::DCC_N-1:0] i_cmp_raw,
	output logic      [dcc_pkg::DCC_N-1:0] o_unit_enable,
	output logic      [dcc_pkg::DCC_N-1:0] o_plus_route,
	output logic      [dcc_pkg::DCC_N-1:0] o_minus_route,
	// output pads
	output logic      [dcc_pkg::DCC_N-1:0] o_pad,
	output logic      [dcc_pkg::DCC_N-1:0] o_pad_oe,
	// interrupt
	output logic                           o_irq
);
	import dcc_pkg::*;

	typedef struct packed {
		dcc_bus_t             bus;
		logic [1:0]           idx;
		logic [DCC_CTRL_W-1:0] ctrl;
		logic [DCC_N-1:0]     stat;
		logic [DCC_N-1:0]     mask;
		logic [DCC_DW-1:0]    rdata;
		logic [DCC_N-1:0]     pad;
		logic [DCC_N-1:0]     pad_oe;
		logic                 irq;
	} dcc_top_state_t;

	dcc_top_state_t   s;
	dcc_top_state_t   next_s;
	logic [DCC_N-1:0] cmp_result;
	logic [DCC_N-1:0] cmp_change;
	logic             accept;
	logic [1:0]       dec_idx;
	logic             wr_now;

	// one unit per comparator
	genvar gi;
	generate
		for (gi = 0; gi < DCC_N; gi++) begin : g_unit
			dcc_unit_if u_if ();
			assign u_if.enable = s.ctrl[DCC_B_EN + gi];
			assign u_if.invert = s.ctrl[DCC_B_INV + gi];
			assign u_if.raw    = i_cmp_raw[gi];
			assign cmp_result[gi] = u_if.result;
			assign cmp_change[gi] = u_if.change;
			dcc_unit u_unit (
				.i_sys_clk (i_sys_clk),
				.i_nrst    (i_nrst),
				.bus       (u_if.unit)
			);
			assign o_unit_enable[gi] = s.ctrl[DCC_B_EN + gi];
			assign o_plus_route[gi]  = s.ctrl[DCC_B_PLUS + DCC_ROUTE_S * gi];
			assign o_minus_route[gi] = s.ctrl[DCC_B_MINUS + DCC_ROUTE_S * gi];
		end
	endgenerate

	// address decode of a new transfer
	always_comb begin
		case (i_haddr[DCC_DEC_W-1:0])
			DCC_OFS_CTRL: dec_idx = DCC_IDX_CTRL;
			DCC_OFS_STAT: dec_idx = DCC_IDX_STAT;
			DCC_OFS_MASK: dec_idx = DCC_IDX_MASK;
			default:      dec_idx = DCC_IDX_NONE;
		endcase
	end

	assign accept = i_hsel & i_hready & (i_htrans == DCC_HTRANS_NONSEQ);
	assign wr_now = (s.bus == DCC_BUS_WR);

	always_comb begin
		next_s = s;

		// bus phase; reads take one wait state so a prior write is visible
		case (s.bus)
			DCC_BUS_IDLE, DCC_BUS_WR, DCC_BUS_RD_DONE: begin
				if (accept) begin
					next_s.bus = i_hwrite ? DCC_BUS_WR : DCC_BUS_RD_WAIT;
					next_s.idx = dec_idx;
				end else begin
					next_s.bus = DCC_BUS_IDLE;
				end
			end
			DCC_BUS_RD_WAIT: begin
				next_s.bus = DCC_BUS_RD_DONE;
				case (s.idx)
					DCC_IDX_CTRL: next_s.rdata = {{(DCC_DW-DCC_CTRL_W){1'b0}}, s.ctrl};
					DCC_IDX_STAT: next_s.rdata = {{(DCC_DW-DCC_N){1'b0}}, s.stat};
					DCC_IDX_MASK: next_s.rdata = {{(DCC_DW-DCC_N){1'b0}}, s.mask};
					default:      next_s.rdata = DCC_RD_RST;
				endcase
			end
			default: begin
				next_s.bus = DCC_BUS_IDLE;
			end
		endcase

		// software writes in the data phase
		if (wr_now && s.idx == DCC_IDX_CTRL) begin
			// unused and result bits not writable
			next_s.ctrl = (s.ctrl & ~DCC_RW_MASK) | (i_hwdata[DCC_CTRL_W-1:0] & DCC_RW_MASK);
			for (int i = 0; i < DCC_N; i++) begin
				next_s.ctrl[DCC_B_EVT + i] = s.ctrl[DCC_B_EVT + i] & i_hwdata[DCC_B_EVT + i];
			end
		end
		if (wr_now && s.idx == DCC_IDX_STAT) begin
			next_s.stat = s.stat & ~i_hwdata[DCC_N-1:0];
		end
		if (wr_now && s.idx == DCC_IDX_MASK) begin
			next_s.mask = i_hwdata[DCC_N-1:0];
		end

		for (int i = 0; i < DCC_N; i++) begin
			// change sets flag, set wins over clear
			next_s.ctrl[DCC_B_EVT + i] = next_s.ctrl[DCC_B_EVT + i] | cmp_change[i];
			next_s.ctrl[DCC_B_RES + i] = cmp_result[i];
		end
		next_s.stat = next_s.stat | cmp_change;

		for (int i = 0; i < DCC_N; i++) begin
			next_s.pad_oe[i] = next_s.ctrl[DCC_B_PAD + i];
			next_s.pad[i]    = next_s.ctrl[DCC_B_PAD + i] & cmp_result[i];
		end

		next_s.irq = (|(next_s.stat & next_s.mask)) & ~(next_s.ctrl[DCC_B_IDLE] & i_idle);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			s.bus    <= DCC_BUS_IDLE;
			s.idx    <= DCC_IDX_NONE;
			s.ctrl   <= DCC_CTRL_RST;
			s.stat   <= DCC_IRQ_RST;
			s.mask   <= DCC_IRQ_RST;
			s.rdata  <= DCC_RD_RST;
			s.pad    <= '0;
			s.pad_oe <= '0;
			s.irq    <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign o_hrdata    = s.rdata;
	assign o_hreadyout = (s.bus != DCC_BUS_RD_WAIT);
	assign o_hresp     = DCC_HRESP_OKAY;
	assign o_pad       = s.pad;
	assign o_pad_oe    = s.pad_oe;
	assign o_irq       = s.irq;
endmodule

// file: sim/dcc_cells.sv
`timescale 1ns/1ps
module dcc_cells (
	// analog levels
	input  wire logic [7:0] i_vp [2],
	input  wire logic [7:0] i_vm,
	input  wire logic [7:0] i_vref,
	// control
	input  wire logic [1:0] i_en,
	input  wire logic [1:0] i_plus_route,
	input  wire logic [1:0] i_minus_route,
	// decisions
	output logic      [1:0] o_raw
);
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			o_raw[i] = i_en[i] & ((i_plus_route[i] ? i_vp[i] : i_vref) >
				(i_minus_route[i] ? i_vp[i] : i_vm));
		end
	end
endmodule

// file: sim/dcc_top_chk.sv
`timescale 1ns/1ps
module dcc_top_chk (
	// bus
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	// device
	input wire logic        i_idle,
	input wire logic [1:0]  o_unit_enable,
	input wire logic [1:0]  o_pad,
	input wire logic [1:0]  o_pad_oe,
	input wire logic        o_irq
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	logic take;
	logic wr_c;
	logic stop;
	assign take = i_hsel && i_hready && i_htrans == 2'h2;
	// shadow of the idle-stop bit
	always_ff @(posedge i_sys_clk) begin
		wr_c <= i_nrst && take && i_hwrite && i_haddr[11:0] == 12'h000;
		stop <= !i_nrst ? 1'b0 : wr_c ? i_hwdata[15] : stop;
	end
	a_resp_okay: assert property (o_hresp == 1'b0)
		else $error("bad response");
	a_read_wait: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait wrong");
	a_write_fast: assert property (take && i_hwrite |=> o_hreadyout)
		else $error("write stalled");
	a_wait_short: assert property (!o_hreadyout |=> o_hreadyout)
		else $error("long wait");
	a_pad_gated: assert property ((o_pad & ~o_pad_oe) == 2'h0)
		else $error("pad driven while off");
	a_off_quiet: assert property (!o_unit_enable[0] [*4] |-> !o_pad[0])
		else $error("disabled unit drives pad");
	a_idle_quiet: assert property (stop && $past(stop) && i_idle && $past(i_idle) |-> !o_irq)
		else $error("irq while idle");
	a_reset_clear: assert property (disable iff (1'b0) !i_nrst |=> !o_irq && o_pad_oe == 2'h0)
		else $error("reset left outputs");
endmodule
bind dcc_top dcc_top_chk u_dcc_top_chk (.*);

// file: sim/dcc_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, v); end end
module dcc_top_tb;
	import dcc_pkg::*;
	logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, idle = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0, raw, en, pr, mr, pad, oe;
	logic        rdy, resp, irq, ia;
	logic [7:0]  vp [2] = '{8'h96, 8'h32};
	int          fails = 0, tests_run = 0;
	initial forever #10 clk = ~clk;
	dcc_top u_dcc_top (.i_sys_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
		.o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp), .i_idle(idle), .i_cmp_raw(raw),
		.o_unit_enable(en), .o_plus_route(pr), .o_minus_route(mr), .o_pad(pad), .o_pad_oe(oe),
		.o_irq(irq));
	dcc_cells u_dcc_cells (.i_vp(vp), .i_vm(8'h50), .i_vref(8'h64), .i_en(en),
		.i_plus_route(pr), .i_minus_route(mr), .o_raw(raw));
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= DCC_HTRANS_NONSEQ;
		hwrite <= w;
		do @(negedge clk); while (rdy !== 1'b1);
		@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge clk); while (rdy !== 1'b1);
		rd = hrdata;
		@(posedge clk);
	endtask
	function automatic logic [1:0] exp_res(input logic [3:0] r);
		for (int i = 0; i < 2; i++)
			exp_res[i] = (r[2*i] ? vp[i] : 8'h64) > (r[2*i+1] ? vp[i] : 8'h50);
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 16; a += 4) begin
			xfer(1'b0, 12'(a), 32'h0000_0000);
			`CHK("reset read", 32'h0000_0000, rd)
		end
		for (int r = 0; r < 16; r++) begin
			xfer(1'b1, DCC_OFS_CTRL, 32'h0000_0F00 | r);
			repeat (6) @(posedge clk);
			xfer(1'b0, DCC_OFS_CTRL, 32'h0000_0000);
			`CHK("result", exp_res(4'(r)), rd[7:6])
			`CHK("pads", {2'b11, exp_res(4'(r))}, {oe, pad})
			`CHK("routes", 4'(r), {mr[1], pr[1], mr[0], pr[0]})
			`CHK("plus routes", {r[2], r[0]}, pr)
			`CHK("fields", {5'h0F, 6'(r)}, {rd[14], rd[11:8], rd[5:0]})
		end
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_0F05);
		repeat (6) @(posedge clk);
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_0F05);
		repeat (6) @(posedge clk);
		xfer(1'b0, DCC_OFS_CTRL, 32'h0000_0000);
		`CHK("steady", 4'h1, {rd[13:12], rd[7:6]})
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_0F35);
		repeat (6) @(posedge clk);
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_3F35);
		xfer(1'b0, DCC_OFS_CTRL, 32'h0000_0000);
		`CHK("inverted", 4'hE, {rd[13:12], rd[7:6]})
		xfer(1'b1, DCC_OFS_MASK, 32'h0000_0000);
		repeat (3) @(posedge clk);
		ia = irq;
		xfer(1'b1, DCC_OFS_MASK, 32'h0000_0003);
		repeat (3) @(posedge clk);
		`CHK("mask", 1'b1, ia ^ irq)
		xfer(1'b1, DCC_OFS_MASK, {30'h0000_0000, {2{~ia}}});
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_BF35);
		idle <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("idle irq", 3'b011, {irq, en})
		idle <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("awake irq", 1'b1, irq)
		xfer(1'b1, DCC_OFS_STAT, 32'h0000_0003);
		repeat (3) @(posedge clk);
		xfer(1'b0, DCC_OFS_STAT, 32'h0000_0000);
		`CHK("cleared", 3'h0, {irq, rd[1:0]})
		xfer(1'b1, DCC_OFS_CTRL, 32'h0000_0335);
		repeat (6) @(posedge clk);
		xfer(1'b0, DCC_OFS_CTRL, 32'h0000_0000);
		`CHK("disabled", 6'h00, {en, pad, rd[7:6]})
		conclude();
	end
endmodule
